/* inc/rfr_pkg.sv */
package rfr_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [5:0] A_CMD  = 6'h01;
  localparam logic [5:0] A_DATA = 6'h02;
  localparam logic [5:0] A_STAT = 6'h03;
  localparam logic [5:0] A_FILL = 6'h04;
  localparam logic [5:0] A_CTRL = 6'h09;
  localparam logic [5:0] A_ERR  = 6'h0A;
  localparam logic [5:0] A_BITF = 6'h0F;
  localparam logic [5:0] A_COD  = 6'h14;
  localparam logic [5:0] A_PW   = 6'h15;
  localparam logic [5:0] A_BFR  = 6'h17;
  localparam logic [5:0] A_DEC  = 6'h1E;
  localparam logic [5:0] A_INT  = 6'h22;
  localparam logic [5:0] A_THR  = 6'h29;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] R_BITF = 8'h00;
  localparam logic [2:0] R_COD  = 3'h1;
  localparam logic [5:0] R_PW   = 6'h10;
  localparam logic [5:0] R_BFR  = 6'h00;
  localparam logic [6:0] R_INT  = 7'h03;
  localparam logic [5:0] R_THR  = 6'h08;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BF_MASK  = 3;
  localparam int BF_ALIGN = 4;
  localparam int DEC_ENH  = 7;
  localparam int DEC_SRC  = 1;
  localparam int BFR_EOF  = 5;
  localparam int BFR_GT   = 2;
  localparam int IN_PON   = 0;
  localparam int IN_PODD  = 1;
  localparam int IN_TXCRC = 2;
  localparam int IN_CRC_VARIANT_SELECT  = 5;
  localparam logic [6:0] IN_MASK = 7'h6F;
  localparam int CT_FLUSH = 0;
  localparam logic [2:0] CODE_B = 3'h0;
  localparam logic [2:0] CODE_A = 3'h1;
  // ****************************************************************
  // commands
  // ****************************************************************
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam logic [7:0] CMD_TX   = 8'h1A;
  localparam logic [7:0] CMD_RX   = 8'h16;
  // ****************************************************************
  // timing, in carrier periods unless noted
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FC_PERIOD_PS  = 73746;
  localparam int FC_CYC = FC_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [11:0] ETU_FC  = 12'h080;
  localparam logic [11:0] HALF_FC = 12'h040;
  localparam logic [11:0] GT_FC   = 12'h080;
  localparam logic [3:0]  N_LO_S  = 4'hA;
  localparam logic [3:0]  N_LO_L  = 4'hB;
  localparam logic [3:0]  N_HI_S  = 4'h2;
  localparam logic [3:0]  N_HI_L  = 4'h3;
  localparam logic [15:0] CRC_PRE_A = 16'h6363;
  localparam logic [15:0] CRC_PRE_B = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h8408;

  typedef enum logic [3:0] {
    T_IDLE, T_SOF_LO, T_SOF_HI, T_LOAD, T_START,
    T_BITS, T_PAR, T_STOP, T_EGT, T_EOF
  } rfr_tx_t;
endpackage : rfr_pkg

/* core/rfr_fifo.sv */
`timescale 1ns/100ps
module rfr_fifo #(
  parameter int W = 8,
  parameter int D = 128
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   flush,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D+1)-1:0]      count
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd;
    logic [AW-1:0]       wr;
    logic [CW-1:0]       cnt;
  } rfr_fifo_t;

  rfr_fifo_t s;
  rfr_fifo_t n;
  logic      wr_ok;
  logic      rd_ok;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(D-1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready  = s.cnt != CW'(D);
  assign out_valid = s.cnt != '0;
  assign out_data  = s.mem[s.rd];
  assign count     = s.cnt;
  assign wr_ok     = in_valid && in_ready;
  assign rd_ok     = out_valid && out_ready;

  always_comb begin
    n = s;
    if (flush) begin
      n.rd  = '0;
      n.wr  = '0;
      n.cnt = '0;
    end else begin
      // a write while full is refused here and never touches storage
      if (wr_ok) begin
        n.mem[s.wr] = in_data;
        n.wr        = bump(s.wr);
      end
      if (rd_ok) begin
        n.rd = bump(s.rd);
      end
      n.cnt = s.cnt + CW'(wr_ok) - CW'(rd_ok);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s.rd  <= '0;
      s.wr  <= '0;
      s.cnt <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : rfr_fifo

/* core/rfr_framer.sv */
`timescale 1ns/100ps
// Function
// - nonzero final bit count sends only that many low bits of last byte
// - first received bit lands at the alignment offset of first byte
// - tag mask select sends only final-bit-count mask bits from queue
// - decoder bit 7 selects the enhanced type A decoding
// - decoder source bit 1 picks card signal or test input pin
// - type A pause lasts 2 times (pause width plus 1) carrier periods
// - type B end frame is 10 or 11 ETU by its length bit
// - type B start frame low and high lengths from two-bit field
// - type B extra guard time in multiples of 128 carrier periods
// - type B frame: start frame, characters with start/stop, end frame
// - a 128-byte queue holds transmit and received data
// - data port writes the queue; each read pops oldest byte
// - fill count always shows bytes stored, up to 128
// - queue clear empties the queue and zeroes the fill count
// - store into full queue sets overflow until queue clear
// - near-full alert while free space is below threshold
// - neither alert when neither quantity is below threshold
// - type A parity enable turns parity on; odd select picks odd or even
// - CRC variant bit 5 picks type A CRC or the 3309 CRC
// - CRC append bit 2 computes CRC over data and sends it after
// - overflow shows as bit 4 of the error flag register
module rfr_framer #(
  parameter int DEPTH  = 128,
  parameter int FC_DIV = rfr_pkg::FC_CYC
) (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic [5:0] REG_ADDR,
  input  wire logic       REG_WE,
  input  wire logic       REG_RE,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       RX_CARD,
  input  wire logic       TEST_IN,
  input  wire logic       RX_STROBE,
  input  wire logic       RX_END,
  output logic            TX_LINE,
  output logic            TX_PAUSE,
  output logic            TX_ACTIVE,
  output logic            RX_ACTIVE,
  output logic            NEAR_FULL,
  output logic            NEAR_EMPTY
);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [7:0]      cmd;
    logic [7:0]      bitf;
    logic [2:0]      cod;
    logic [5:0]      pw;
    logic [5:0]      bfr;
    logic            enh;
    logic            src;
    logic [6:0]      integ;
    logic [5:0]      thr;
    logic            ovf;
    logic            parerr;
    logic [7:0]      rdata;
    logic [3:0]      s1;
    logic [3:0]      s2;
    logic [3:0]      s3;
    logic [2:0]      hist;
    logic [7:0]      div;
    rfr_pkg::rfr_tx_t tst;
    logic [11:0]     tcnt;
    logic [7:0]      sh;
    logic [3:0]      bi;
    logic [3:0]      nb;
    logic            pacc;
    logic            pb;
    logic [15:0]     crc;
    logic [1:0]      crcl;
    logic            line;
    logic            pause;
    logic            ract;
    logic [2:0]      pos;
    logic            rany;
    logic [7:0]      racc;
    logic [3:0]      rcnt;
    logic            rpar;
    logic            push;
    logic [7:0]      pbyte;
    logic            hi;
    logic            lo;
  } rfr_state_t;

  rfr_state_t s;
  rfr_state_t n;

  logic          host_wr;
  logic          host_rd;
  logic          tx_pop;
  logic          flush;
  logic          fc_tick;
  logic          a_mode;
  logic          b_mode;
  logic          mask;
  logic [2:0]    fin;
  logic          rx_bit;
  logic          stb;
  logic          endp;
  logic          cur;
  logic [11:0]   dur;
  logic [11:0]   pst;
  logic [11:0]   pend;
  logic [15:0]   crc_out;
  logic          f_in_valid;
  logic          f_in_ready;
  logic [7:0]    f_in_data;
  logic          f_ovalid;
  logic [7:0]    f_odata;
  logic [CW-1:0] f_count;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                            input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ rfr_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  function automatic logic [11:0] etus(input logic [3:0] k);
    return 12'(k * rfr_pkg::ETU_FC);
  endfunction : etus

  function automatic logic maj(input logic [2:0] h);
    return (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
  endfunction : maj

  // ****************************************************************
  // byte queue
  // ****************************************************************
  rfr_fifo #(
    .W (8),
    .D (DEPTH)
  ) u_queue (
    .clk       (CLK),
    .srst      (SRST),
    .flush     (flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_ovalid),
    .out_ready (host_rd || tx_pop),
    .out_data  (f_odata),
    .count     (f_count)
  );

  assign f_in_valid = s.push || host_wr;
  assign f_in_data  = s.push ? s.pbyte : REG_WDATA;
  assign host_wr = REG_WE && (REG_ADDR == rfr_pkg::A_DATA);
  assign host_rd = REG_RE && (REG_ADDR == rfr_pkg::A_DATA) && f_ovalid;
  assign flush = REG_WE && (REG_ADDR == rfr_pkg::A_CTRL)
                 && REG_WDATA[rfr_pkg::CT_FLUSH];

  assign a_mode  = s.cod == rfr_pkg::CODE_A;
  assign b_mode  = s.cod == rfr_pkg::CODE_B;
  assign mask    = s.bitf[rfr_pkg::BF_MASK];
  assign fin     = s.bitf[2:0];
  assign fc_tick = s.div == 8'(FC_DIV - 1);
  assign crc_out = s.integ[rfr_pkg::IN_CRC_VARIANT_SELECT] ? ~s.crc : s.crc;

  always_comb begin
    case (s.tst)
      rfr_pkg::T_SOF_LO:
        dur = etus(s.bfr[1] ? rfr_pkg::N_LO_L : rfr_pkg::N_LO_S);
      rfr_pkg::T_SOF_HI:
        dur = etus(s.bfr[0] ? rfr_pkg::N_HI_L : rfr_pkg::N_HI_S);
      rfr_pkg::T_EGT:
        dur = 12'(s.bfr[4:2] * rfr_pkg::GT_FC);
      rfr_pkg::T_EOF:
        dur = etus(s.bfr[rfr_pkg::BFR_EOF] ? rfr_pkg::N_LO_L
                                           : rfr_pkg::N_LO_S);
      default:
        dur = rfr_pkg::ETU_FC;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n      = s;
    tx_pop = 1'b0;
    n.push = 1'b0;
    n.div  = fc_tick ? 8'h00 : s.div + 8'h01;
    n.s1   = {RX_END, RX_STROBE, TEST_IN, RX_CARD};
    n.s2   = s.s1;
    n.s3   = s.s2;
    n.hist = {s.hist[1:0], s.src ? s.s2[1] : s.s2[0]};
    rx_bit = s.enh ? maj(s.hist) : s.hist[0];
    stb    = s.s2[2] & ~s.s3[2];
    endp   = s.s2[3] & ~s.s3[3];

    if (REG_WE) begin
      case (REG_ADDR)
        rfr_pkg::A_BITF: n.bitf  = REG_WDATA;
        rfr_pkg::A_COD:  n.cod   = REG_WDATA[2:0];
        rfr_pkg::A_PW:   n.pw    = REG_WDATA[5:0];
        rfr_pkg::A_BFR:  n.bfr   = REG_WDATA[5:0];
        rfr_pkg::A_INT:  n.integ = REG_WDATA[6:0] & rfr_pkg::IN_MASK;
        rfr_pkg::A_THR:  n.thr   = REG_WDATA[5:0];
        rfr_pkg::A_DEC: begin
          n.enh = REG_WDATA[rfr_pkg::DEC_ENH];
          n.src = REG_WDATA[rfr_pkg::DEC_SRC];
        end
        rfr_pkg::A_CMD: begin
          n.cmd = REG_WDATA;
          if (REG_WDATA == rfr_pkg::CMD_TX) begin
            n.tst  = b_mode ? rfr_pkg::T_SOF_LO : rfr_pkg::T_LOAD;
            n.tcnt = '0;
            // frame timing starts on a carrier boundary
            n.div  = 8'h00;
            n.pb   = 1'b0;
            n.crc  = s.integ[rfr_pkg::IN_CRC_VARIANT_SELECT] ? rfr_pkg::CRC_PRE_B
                                               : rfr_pkg::CRC_PRE_A;
            n.crcl = (s.integ[rfr_pkg::IN_TXCRC] && !mask)
                     ? 2'd2 : 2'd0;
          end else if (REG_WDATA == rfr_pkg::CMD_RX) begin
            n.ract   = 1'b1;
            n.pos    = s.bitf[rfr_pkg::BF_ALIGN +: 3];
            n.rany   = 1'b0;
            n.racc   = '0;
            n.rcnt   = '0;
            n.rpar   = 1'b0;
            n.parerr = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // transmit framing
    case (s.tst)
      rfr_pkg::T_IDLE: ;
      rfr_pkg::T_LOAD: begin
        n.bi   = '0;
        n.pacc = 1'b0;
        n.tcnt = '0;
        n.tst  = b_mode ? rfr_pkg::T_START : rfr_pkg::T_BITS;
        n.nb   = 4'd8;
        if (f_ovalid && !host_rd) begin
          tx_pop = 1'b1;
          n.sh   = f_odata;
          n.crc  = crc_byte(s.crc, f_odata);
          if (mask) begin
            n.nb = {1'b0, fin};
          end else if (f_count == CW'(1) && fin != 3'd0) begin
            n.nb = {1'b0, fin};
          end
        end else if (f_ovalid) begin
          n.tst = rfr_pkg::T_LOAD;
        end else if (s.crcl != 2'd0) begin
          n.sh   = (s.crcl == 2'd2) ? crc_out[7:0] : crc_out[15:8];
          n.crcl = s.crcl - 2'd1;
        end else if (b_mode) begin
          n.tst = rfr_pkg::T_EOF;
        end else begin
          n.tst = rfr_pkg::T_IDLE;
          n.cmd = rfr_pkg::CMD_IDLE;
        end
      end
      default: begin
        if (fc_tick) begin
          n.tcnt = s.tcnt + 12'd1;
          if (s.tcnt == dur - 12'd1) begin
            n.tcnt = '0;
            case (s.tst)
              rfr_pkg::T_SOF_LO: n.tst = rfr_pkg::T_SOF_HI;
              rfr_pkg::T_SOF_HI: n.tst = rfr_pkg::T_LOAD;
              rfr_pkg::T_START:  n.tst = rfr_pkg::T_BITS;
              rfr_pkg::T_BITS: begin
                n.pb   = s.sh[0];
                n.pacc = s.pacc ^ s.sh[0];
                n.sh   = s.sh >> 1;
                n.bi   = s.bi + 4'd1;
                if (s.bi + 4'd1 == s.nb) begin
                  if (mask) begin
                    n.tst = rfr_pkg::T_IDLE;
                    n.cmd = rfr_pkg::CMD_IDLE;
                  end else if (a_mode && s.integ[rfr_pkg::IN_PON]
                               && s.nb == 4'd8) begin
                    n.tst = rfr_pkg::T_PAR;
                  end else if (b_mode) begin
                    n.tst = rfr_pkg::T_STOP;
                  end else begin
                    n.tst = rfr_pkg::T_LOAD;
                  end
                end
              end
              rfr_pkg::T_PAR: begin
                n.pb  = s.integ[rfr_pkg::IN_PODD] ^ s.pacc;
                n.tst = rfr_pkg::T_LOAD;
              end
              rfr_pkg::T_STOP:
                n.tst = (s.bfr[4:2] != 3'd0) ? rfr_pkg::T_EGT
                                             : rfr_pkg::T_LOAD;
              rfr_pkg::T_EGT: n.tst = rfr_pkg::T_LOAD;
              default: begin
                n.tst = rfr_pkg::T_IDLE;
                n.cmd = rfr_pkg::CMD_IDLE;
              end
            endcase
          end
        end
      end
    endcase

    // line level and type A pause placement
    cur = (n.tst == rfr_pkg::T_PAR)
          ? (s.integ[rfr_pkg::IN_PODD] ^ n.pacc) : n.sh[0];
    case (n.tst)
      rfr_pkg::T_SOF_LO, rfr_pkg::T_START, rfr_pkg::T_EOF:
        n.line = 1'b0;
      rfr_pkg::T_BITS, rfr_pkg::T_PAR:
        n.line = cur;
      // in type B the load cycle is the first cycle of the low start or end bit
      rfr_pkg::T_LOAD:
        n.line = !b_mode;
      default:
        n.line = 1'b1;
    endcase
    pst     = cur ? rfr_pkg::HALF_FC : 12'd0;
    pend    = pst + {5'd0, n.pw, 1'b0} + 12'd2;
    // a zero right after a one carries no pause (modified Miller)
    // window runs one clock late so the load cycle is counted
    n.pause = a_mode && (n.tst == rfr_pkg::T_BITS
                         || n.tst == rfr_pkg::T_PAR)
              && (cur || !n.pb)
              && (n.tcnt > pst || (n.tcnt == pst && n.div != 8'h00))
              && (n.tcnt < pend
                  || (n.tcnt == pend && n.div == 8'h00));

    // receive assembly
    if (s.ract) begin
      if (endp) begin
        n.ract = 1'b0;
        n.cmd  = rfr_pkg::CMD_IDLE;
        n.push = s.rany;
        n.pbyte = s.racc;
      end else if (stb) begin
        if (a_mode && s.integ[rfr_pkg::IN_PON] && s.rcnt == 4'd8) begin
          if (rx_bit != (s.integ[rfr_pkg::IN_PODD] ^ s.rpar)) begin
            n.parerr = 1'b1;
          end
          n.rcnt = '0;
          n.rpar = 1'b0;
        end else begin
          n.racc[s.pos] = rx_bit;
          n.rpar = s.rpar ^ rx_bit;
          n.rcnt = s.rcnt + 4'd1;
          n.rany = 1'b1;
          n.pos  = s.pos + 3'd1;
          if (s.pos == 3'd7) begin
            n.push  = 1'b1;
            n.pbyte = n.racc;
            n.racc  = '0;
            n.rany  = 1'b0;
          end
        end
      end
    end

    // overflow: a clear wins over a set in the same cycle
    if (flush) begin
      n.ovf = 1'b0;
    end
    if (f_in_valid && !f_in_ready && !flush) begin
      n.ovf = 1'b1;
    end

    n.hi = (CW'(DEPTH) - f_count) < CW'(s.thr);
    n.lo = f_count < CW'(s.thr);

    if (REG_RE) begin
      case (REG_ADDR)
        rfr_pkg::A_CMD:  n.rdata = s.cmd;
        rfr_pkg::A_DATA: n.rdata = f_ovalid ? f_odata : 8'h00;
        rfr_pkg::A_STAT: n.rdata = {6'h00, s.hi, s.lo};
        rfr_pkg::A_FILL: n.rdata = 8'(f_count);
        rfr_pkg::A_ERR:  n.rdata = {3'h0, s.ovf, 2'h0, s.parerr, 1'b0};
        rfr_pkg::A_BITF: n.rdata = s.bitf;
        rfr_pkg::A_COD:  n.rdata = {5'h00, s.cod};
        rfr_pkg::A_PW:   n.rdata = {2'h0, s.pw};
        rfr_pkg::A_BFR:  n.rdata = {2'h0, s.bfr};
        rfr_pkg::A_DEC:  n.rdata = {s.enh, 5'h00, s.src, 1'b1};
        rfr_pkg::A_INT:  n.rdata = {1'b0, s.integ};
        rfr_pkg::A_THR:  n.rdata = {2'h0, s.thr};
        default:         n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s       <= '0;
      s.bitf  <= rfr_pkg::R_BITF;
      s.cod   <= rfr_pkg::R_COD;
      s.pw    <= rfr_pkg::R_PW;
      s.bfr   <= rfr_pkg::R_BFR;
      s.integ <= rfr_pkg::R_INT;
      s.thr   <= rfr_pkg::R_THR;
      s.line  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign REG_RDATA  = s.rdata;
  assign TX_LINE    = s.line;
  assign TX_PAUSE   = s.pause;
  assign TX_ACTIVE  = s.tst != rfr_pkg::T_IDLE;
  assign RX_ACTIVE  = s.ract;
  assign NEAR_FULL  = s.hi;
  assign NEAR_EMPTY = s.lo;
endmodule : rfr_framer

/* sim/rfr_framer_monitor.sv */
`timescale 1ns/100ps
module rfr_framer_monitor #(
  parameter int FC_DIV = 18
) (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [5:0] REG_ADDR,
  input wire logic       REG_WE,
  input wire logic       REG_RE,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       TX_LINE,
  input wire logic       TX_PAUSE,
  input wire logic       TX_ACTIVE,
  input wire logic       RX_ACTIVE,
  input wire logic       NEAR_FULL,
  input wire logic       NEAR_EMPTY
);
  logic [5:0]  pw;
  logic [5:0]  thr;
  logic [15:0] pcnt;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // ****
  // shadow of settings the checks depend on
  // ****
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pw  <= rfr_pkg::R_PW;
      thr <= rfr_pkg::R_THR;
    end else if (REG_WE && REG_ADDR == rfr_pkg::A_PW) begin
      pw <= REG_WDATA[5:0];
    end else if (REG_WE && REG_ADDR == rfr_pkg::A_THR) begin
      thr <= REG_WDATA[5:0];
    end
    pcnt <= TX_PAUSE ? pcnt + 16'h0001 : 16'h0000;
  end
  chk_reset_idle: assert property ($fell(SRST) |->
    TX_LINE && !TX_PAUSE && !TX_ACTIVE && !RX_ACTIVE)
    else $error("outputs not idle after reset");
  chk_rdata_hold: assert property (!REG_RE |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  chk_alert_excl: assert property (!(NEAR_FULL && NEAR_EMPTY))
    else $error("both queue alerts high");
  chk_flush_empty: assert property (REG_WE && REG_ADDR == rfr_pkg::A_CTRL &&
    REG_WDATA[0] |-> ##[1:3] (NEAR_EMPTY == (thr != 6'h00)))
    else $error("near empty wrong after clear");
  chk_pause_width: assert property ($fell(TX_PAUSE) |->
    pcnt == 2 * (pw + 1) * FC_DIV)
    else $error("pause width wrong");
  chk_pause_in_tx: assert property (TX_PAUSE |->
    TX_ACTIVE || $past(TX_ACTIVE))
    else $error("pause outside transmit");
  chk_tx_start: assert property (REG_WE && REG_ADDR == rfr_pkg::A_CMD &&
    REG_WDATA == rfr_pkg::CMD_TX |-> ##[1:4] TX_ACTIVE)
    else $error("transmit did not start");
  chk_rx_start: assert property (REG_WE && REG_ADDR == rfr_pkg::A_CMD &&
    REG_WDATA == rfr_pkg::CMD_RX |-> ##[1:4] RX_ACTIVE)
    else $error("receive did not start");
  chk_idle_line: assert property (!TX_ACTIVE [*3] |-> TX_LINE)
    else $error("line low while idle");
  cover property ($fell(TX_PAUSE));
  cover property ($fell(RX_ACTIVE));
  cover property (NEAR_FULL);
endmodule : rfr_framer_monitor

bind rfr_framer rfr_framer_monitor #(.FC_DIV(FC_DIV)) u_mon (.CLK, .SRST,
  .REG_ADDR, .REG_WE, .REG_RE, .REG_WDATA, .REG_RDATA, .TX_LINE, .TX_PAUSE,
  .TX_ACTIVE, .RX_ACTIVE, .NEAR_FULL, .NEAR_EMPTY);

/* sim/rfr_host.sv */
`timescale 1ns/100ps
module rfr_host (
  input  wire logic       CLK,
  output logic      [5:0] REG_ADDR,
  output logic            REG_WE,
  output logic            REG_RE,
  output logic      [7:0] REG_WDATA,
  input  wire logic [7:0] REG_RDATA
);
  initial begin
    REG_ADDR  = 6'h00;
    REG_WE    = 1'b0;
    REG_RE    = 1'b0;
    REG_WDATA = 8'h00;
  end
  // ****
  // one strobe per access, released after the taking edge
  // ****
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK) #1;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WE    = 1'b1;
    @(posedge CLK) #1;
    REG_WE    = 1'b0;
    REG_WDATA = ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge CLK) #1;
    REG_ADDR = a;
    REG_RE   = 1'b1;
    @(posedge CLK) #1;
    REG_RE   = 1'b0;
    d        = REG_RDATA;
  endtask : rd
endmodule : rfr_host

/* sim/rfr_framer_tb_top.sv */
`timescale 1ns/100ps
module rfr_framer_tb_top;
  localparam int FCD = 2;
  localparam int ETU = 128 * FCD;
  logic       CLK = 1'b0;
  logic       SRST = 1'b1;
  logic       RX_CARD = 1'b0;
  logic       TEST_IN = 1'b0;
  logic       RX_STROBE = 1'b0;
  logic       RX_END = 1'b0;
  logic [5:0] REG_ADDR;
  logic       REG_WE;
  logic       REG_RE;
  logic [7:0] REG_WDATA;
  logic [7:0] REG_RDATA;
  logic       TX_LINE;
  logic       TX_PAUSE;
  logic       TX_ACTIVE;
  logic       RX_ACTIVE;
  logic       NEAR_FULL;
  logic       NEAR_EMPTY;
  int         miscompares = 0;
  int         compares = 0;
  logic [7:0] v;
  int         c;
  logic [13:0] rows [9] = '{{6'h0F, 8'h00}, {6'h14, 8'h01}, {6'h15, 8'h10},
    {6'h17, 8'h00}, {6'h1E, 8'h01}, {6'h22, 8'h03}, {6'h29, 8'h08},
    {6'h04, 8'h00}, {6'h3F, 8'h00}};
  always #2 CLK = ~CLK;
  rfr_host host (.CLK, .REG_ADDR, .REG_WE, .REG_RE, .REG_WDATA, .REG_RDATA);
  rfr_framer #(.FC_DIV(FCD)) i_rfr_framer (.CLK, .SRST, .REG_ADDR, .REG_WE,
    .REG_RE, .REG_WDATA, .REG_RDATA, .RX_CARD, .TEST_IN, .RX_STROBE,
    .RX_END, .TX_LINE, .TX_PAUSE, .TX_ACTIVE, .RX_ACTIVE, .NEAR_FULL,
    .NEAR_EMPTY);
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  // length of a run of one level on the line or the pause output
  task automatic run(input logic p, input logic lvl, output int n);
    n = 0;
    while ((p ? TX_PAUSE : TX_LINE) === lvl && n < 9000) begin
      tick(1);
      n++;
    end
  endtask : run
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
  initial begin
    tick(5);
    SRST = 1'b0;
    foreach (rows[i]) begin
      host.rd(rows[i][13:8], v);
      chk("reset reg", v, rows[i][7:0]);
    end
    $display("reset values done");
    host.wr(6'h02, 8'h5A);
    host.wr(6'h02, 8'hC3);
    host.rd(6'h04, v);
    chk("fill", v, 8'h02);
    host.rd(6'h02, v);
    chk("pop", v, 8'h5A);
    host.rd(6'h02, v);
    chk("pop", v, 8'hC3);
    host.rd(6'h02, v);
    chk("empty pop", v, 8'h00);
    host.rd(6'h04, v);
    chk("fill", v, 8'h00);
    for (int i = 0; i < 8; i++) host.wr(6'h02, 8'hA0);
    host.rd(6'h03, v);
    chk("alerts", v[1:0], 2'b00);
    for (int i = 8; i < 129; i++) host.wr(6'h02, 8'hA0);
    host.rd(6'h04, v);
    chk("fill", v, 8'h80);
    host.rd(6'h0A, v);
    chk("overflow", v[4], 1'b1);
    chk("near full", {NEAR_FULL, NEAR_EMPTY}, 2'b10);
    host.wr(6'h09, 8'h01);
    host.rd(6'h0A, v);
    chk("overflow", v[4], 1'b0);
    host.rd(6'h03, v);
    chk("alerts", v[1:0], 2'b01);
    $display("queue done");
    // ****
    // type B frames: two bytes so the guard sits between characters
    // ****
    for (int k = 0; k < 2; k++) begin
      host.wr(6'h22, 8'h20);
      host.wr(6'h14, 8'h00);
      host.wr(6'h17, k ? 8'h3F : 8'h00);
      host.wr(6'h02, 8'hFF);
      host.wr(6'h02, 8'hFF);
      host.wr(6'h01, 8'h1A);
      run(1'b0, 1'b1, c);
      run(1'b0, 1'b0, c);
      chk("sof low", c, (10 + k) * ETU);
      run(1'b0, 1'b1, c);
      chk("sof high", c, (2 + k) * ETU);
      run(1'b0, 1'b0, c);
      chk("start bit", c, ETU);
      run(1'b0, 1'b1, c);
      chk("char gap", c, 9 * ETU + 7 * k * ETU);
      run(1'b0, 1'b0, c);
      run(1'b0, 1'b1, c);
      run(1'b0, 1'b0, c);
      chk("eof", c, (10 + k) * ETU);
      tick(8);
      chk("idle", {TX_LINE, TX_ACTIVE}, 2'b10);
    end
    $display("type B done");
    host.wr(6'h22, 8'h03);
    host.wr(6'h14, 8'h01);
    host.wr(6'h15, 8'h05);
    host.wr(6'h02, 8'h00);
    host.wr(6'h01, 8'h1A);
    run(1'b1, 1'b0, c);
    run(1'b1, 1'b1, c);
    chk("pause", c, 2 * 6 * FCD);
    for (c = 0; TX_ACTIVE === 1'b1 && c < 9000; c++) tick(1);
    host.rd(6'h01, v);
    chk("command", v, 8'h00);
    $display("type A done");
    // both decoder sources, only the selected one carries ones
    for (int s = 0; s < 2; s++) begin
      host.wr(6'h09, 8'h01);
      host.wr(6'h1E, s ? 8'h83 : 8'h81);
      RX_CARD = (s == 0);
      TEST_IN = (s == 1);
      host.wr(6'h0F, 8'h30);
      host.wr(6'h01, 8'h16);
      repeat (5) begin
        RX_STROBE = 1'b1;
        tick(8);
        RX_STROBE = 1'b0;
        tick(8);
      end
      RX_END = 1'b1;
      tick(8);
      RX_END = 1'b0;
      tick(8);
      host.rd(6'h02, v);
      chk("rx byte", v, 8'hF8);
    end
    $display("receive done");
    test_done();
  end
endmodule : rfr_framer_tb_top
